// >>> logic/flash_params_powerup.sv
`timescale 1ns/1ps
// How it works
// - Maximum supply code reads 00h then 36h.
// - Minimum supply code reads 00h then 27h.
// - Hardware capability word reads 4FF6h.
// - Wrap opcode and length bytes read FFh.
// - Protection capability word reads CFFEh.
// - Unused table bytes read FFh.
// - Power-up: standby, write latch flag clear.
// - Delivered status register 00h.
// - Deep power-down reached within 10 us.
// - Wake to standby within 8.8 us.
// - Status write finishes within 100 ms.
// - Page 5 ms, single byte 300 us.
// - Sector erase finishes within 300 ms.
// - Block 2 s, chip 15 s.
module flash_params_powerup #(
	parameter logic [31:0] PD_ENTRY_CYCLES = flash_params_pkg::PD_ENTRY_CYC,
	parameter logic [31:0] WAKE_CYCLES     = flash_params_pkg::WAKE_CYC,
	parameter logic [31:0] WAKE_ID_CYCLES  = flash_params_pkg::WAKE_ID_CYC,
	parameter logic [31:0] SRW_CYCLES      = flash_params_pkg::SRW_CYC,
	parameter logic [31:0] BYTE_CYCLES     = flash_params_pkg::BYTE_CYC,
	parameter logic [31:0] PAGE_CYCLES     = flash_params_pkg::PAGE_CYC,
	parameter logic [31:0] SECTOR_CYCLES   = flash_params_pkg::SECTOR_CYC,
	parameter logic [31:0] BLOCK_CYCLES    = flash_params_pkg::BLOCK_CYC,
	parameter logic [31:0] CHIP_CYCLES     = flash_params_pkg::CHIP_CYC
) (
	// Clock and power-on reset
	input  wire logic                   mclk,
	input  wire logic                   reset,
	// Parameter table read port
	input  wire logic [7:0]             table_addr,
	output logic [7:0]                  table_data,
	// Write latch control
	input  wire logic                   latch_set,
	input  wire logic                   latch_clear,
	// Internal operation request
	input  wire logic                   op_start,
	input  wire flash_params_pkg::op_t  op_kind,
	// Power-down requests, given at chip-select rise
	input  wire logic                   powerdown_req,
	input  wire logic                   wake_req,
	input  wire logic                   wake_with_id,
	// Status
	output logic                        busy,
	output logic                        write_latch_flag,
	output logic                        in_powerdown,
	output logic                        in_standby,
	output logic [7:0]                  status_byte
);
	import flash_params_pkg::*;

	state_t      state_reg, state_next;
	logic [31:0] count_reg, count_next;
	logic        latch_reg;
	logic [7:0]  data_reg;
	logic [31:0] op_limit;
	logic [31:0] wake_limit;
	logic [7:0]  table_byte;
	logic        in_table;
	logic [3:0]  idx;
	logic        st_standby;
	logic        st_busy;
	logic        st_pd_enter;
	logic        st_pd;
	logic        count_done;
	logic        op_taken;
	logic        pd_taken;
	logic        wake_taken;
	logic        op_finish;

	// Constant table lookup; writes have no path to it
	// Addresses outside the window read blank, as undefined bytes do
	// Words sit low byte first, so a host reading upward sees each
	// 16-bit field in little-endian order
	assign in_table = (table_addr >= TABLE_BASE) &&
		(table_addr <= TABLE_LAST);
	// Only the low nibble indexes; the window check blanks the rest
	assign idx = table_addr[3:0];
	always_comb begin
		case (idx)
			4'h0: table_byte = VMAX_LO;
			4'h1: table_byte = VMAX_HI;
			4'h2: table_byte = VMIN_LO;
			4'h3: table_byte = VMIN_HI;
			4'h4: table_byte = HW_CAPS[7:0];
			4'h5: table_byte = HW_CAPS[15:8];
			4'h6: table_byte = WRAP_OPCODE;
			4'h7: table_byte = WRAP_LENGTH;
			4'h8: table_byte = PROT_CAPS[7:0];
			4'h9: table_byte = PROT_CAPS[15:8];
			default: table_byte = BLANK_BYTE;
		endcase
	end

	// Cycle budget per operation, each at its worst-case bound
	// Only the maximum figure is modelled; a real part often finishes
	// near its typical time, so a host should poll busy rather than
	// count on the full budget
	always_comb begin
		case (op_kind)
			OP_STATUS_WRITE: op_limit = SRW_CYCLES;
			OP_BYTE_PROGRAM: op_limit = BYTE_CYCLES;
			OP_PAGE_PROGRAM: op_limit = PAGE_CYCLES;
			OP_SECTOR_CLEAR: op_limit = SECTOR_CYCLES;
			OP_BLOCK_CLEAR:  op_limit = BLOCK_CYCLES;
			OP_CHIP_CLEAR:   op_limit = CHIP_CYCLES;
			default:         op_limit = PAGE_CYCLES;
		endcase
	end
	// Both wake figures are equal by default; the pick is read on
	// the edge that takes the wake request
	assign wake_limit = wake_with_id ? WAKE_ID_CYCLES : WAKE_CYCLES;

	// Named decodes of the sequencer state and of request acceptance;
	// the outputs read these instead of the raw state code; the next-state case selects on state_reg
	assign st_standby  = (state_reg == ST_STANDBY);
	assign st_busy     = (state_reg == ST_BUSY);
	assign st_pd_enter = (state_reg == ST_PD_ENTER);
	assign st_pd       = (state_reg == ST_POWERDOWN);
	// A counter at one marks the last cycle of a timed state
	assign count_done  = (count_reg <= 32'h00000001);
	// An operation start outranks a power-down in the same cycle
	assign op_taken    = st_standby && op_start;
	assign pd_taken    = st_standby && !op_start && powerdown_req;
	assign wake_taken  = st_pd && wake_req;
	// The internal cycle ends on the edge that leaves the busy state
	assign op_finish   = st_busy && count_done;

	// Power and busy sequencer; counter loads on entry, counts to 1
	// A counter loaded with N of 1 or more holds its state for exactly N cycles; a load of 0 holds it for one cycle.
	// A request that the current state cannot take is dropped without
	// trace; the host sees that only on the status outputs
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		case (state_reg)
			// Idle: the only state that takes new work
			ST_STANDBY: begin
				if (op_taken) begin
					state_next = ST_BUSY;
					count_next = op_limit;
				end else if (pd_taken) begin
					state_next = ST_PD_ENTER;
					count_next = PD_ENTRY_CYCLES;
				end
			end
			// Timed states: count down, leave on the last cycle
			ST_BUSY, ST_PD_ENTER, ST_WAKE: begin
				if (count_done) begin
					count_next = 32'h00000000;
					state_next = st_pd_enter ?
						ST_POWERDOWN : ST_STANDBY;
				end else begin
					count_next = count_reg - 32'h00000001;
				end
			end
			// Deep power-down: only a wake request is heard
			ST_POWERDOWN: begin
				if (wake_taken) begin
					state_next = ST_WAKE;
					count_next = wake_limit;
				end
			end
			// Unused codes fall back to standby
			default: begin
				state_next = ST_STANDBY;
				count_next = 32'h00000000;
			end
		endcase
	end

	// Sequencer registers; power-on lands in standby
	// With no reset pin, power-on reset is the only way to force standby
	// The counter is cleared too so that no stale budget survives
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= ST_STANDBY;
			count_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// Write latch: set wins over clear; an operation consumes it on the edge that ends it
	// The latch is spent by the operation that it enabled
	always_ff @(posedge mclk) begin
		if (reset)
			latch_reg <= 1'b0;
		else if (latch_set)
			latch_reg <= 1'b1;
		else if (latch_clear || op_finish)
			latch_reg <= 1'b0;
	end

	// Registered table data, blank outside the defined window
	// One cycle of lag buys a data output straight from flip-flops
	always_ff @(posedge mclk) begin
		if (reset)
			data_reg <= BLANK_BYTE;
		else
			data_reg <= in_table ? table_byte : BLANK_BYTE;
	end

	// Status outputs; status reads 00h when idle with latch clear
	// Upper status bits have no owner here and keep their delivery value
	// Busy is the in-progress bit; the latch sits just above it
	assign table_data       = data_reg;
	assign busy             = st_busy;
	assign write_latch_flag = latch_reg;
	assign in_powerdown     = st_pd;
	assign in_standby       = st_standby;
	assign status_byte      = STATUS_DELIVERY |
		{6'h00, latch_reg, busy};

endmodule

// >>> logic/flash_params_pkg.sv
package flash_params_pkg;

	// Parameter table window and values
	localparam logic [7:0] TABLE_BASE      = 8'h60;
	localparam logic [7:0] TABLE_LAST      = 8'h6F;
	localparam logic [7:0] BLANK_BYTE      = 8'hFF;
	localparam logic [7:0] VMAX_LO         = 8'h00;
	localparam logic [7:0] VMAX_HI         = 8'h36;
	localparam logic [7:0] VMIN_LO         = 8'h00;
	localparam logic [7:0] VMIN_HI         = 8'h27;
	localparam logic [15:0] HW_CAPS        = 16'h4FF6;
	localparam logic [7:0] WRAP_OPCODE     = 8'hFF;
	localparam logic [7:0] WRAP_LENGTH     = 8'hFF;
	localparam logic [15:0] PROT_CAPS      = 16'hCFFE;
	localparam logic [7:0] STATUS_DELIVERY = 8'h00;

	// Timing figures in their own units; 100 MHz clock
	localparam longint CLK_MHZ = 100;
	localparam longint POWERDOWN_ENTRY_DELAY_NS   = 10000;
	localparam longint WAKE_DELAY_NO_ID_NS        = 8800;
	localparam longint WAKE_DELAY_WITH_ID_NS      = 8800;
	localparam longint STATUS_WRITE_CYCLE_TIME_MS = 100;
	localparam longint SINGLE_BYTE_PROGRAM_TIME_US = 300;
	localparam longint PAGE_WRITE_CYCLE_TIME_MS   = 5;
	localparam longint SECTOR_CLEAR_TIME_MS       = 300;
	localparam longint BLOCK_CLEAR_TIME_S         = 2;
	localparam longint WHOLE_ARRAY_CLEAR_TIME_S   = 15;
	localparam longint POWERUP_SELECT_DELAY_US    = 200;

	// Longest times round down to whole cycles
	localparam logic [31:0] PD_ENTRY_CYC =
		32'(POWERDOWN_ENTRY_DELAY_NS * CLK_MHZ / 1000);
	localparam logic [31:0] WAKE_CYC =
		32'(WAKE_DELAY_NO_ID_NS * CLK_MHZ / 1000);
	localparam logic [31:0] WAKE_ID_CYC =
		32'(WAKE_DELAY_WITH_ID_NS * CLK_MHZ / 1000);
	localparam logic [31:0] SRW_CYC =
		32'(STATUS_WRITE_CYCLE_TIME_MS * CLK_MHZ * 1000);
	localparam logic [31:0] BYTE_CYC =
		32'(SINGLE_BYTE_PROGRAM_TIME_US * CLK_MHZ);
	localparam logic [31:0] PAGE_CYC =
		32'(PAGE_WRITE_CYCLE_TIME_MS * CLK_MHZ * 1000);
	localparam logic [31:0] SECTOR_CYC =
		32'(SECTOR_CLEAR_TIME_MS * CLK_MHZ * 1000);
	localparam logic [31:0] BLOCK_CYC =
		32'(BLOCK_CLEAR_TIME_S * CLK_MHZ * 1000000);
	localparam logic [31:0] CHIP_CYC =
		32'(WHOLE_ARRAY_CLEAR_TIME_S * CLK_MHZ * 1000000);

	// Internal operations the engine can run
	typedef enum logic [2:0] {
		OP_STATUS_WRITE = 3'b000,
		OP_BYTE_PROGRAM = 3'b001,
		OP_PAGE_PROGRAM = 3'b010,
		OP_SECTOR_CLEAR = 3'b011,
		OP_BLOCK_CLEAR  = 3'b100,
		OP_CHIP_CLEAR   = 3'b101
	} op_t;

	// Power and busy states
	typedef enum logic [2:0] {
		ST_STANDBY   = 3'b000,
		ST_BUSY      = 3'b001,
		ST_PD_ENTER  = 3'b010,
		ST_POWERDOWN = 3'b011,
		ST_WAKE      = 3'b100
	} state_t;

endpackage

// >>> bench/host_model.sv
`timescale 1ns/1ps
// Host side: no select until the supply has settled
module host_model #(
	parameter int POWERUP_SELECT_DELAY = 20
) (
	// Clock and power-on reset
	input  wire logic mclk,
	input  wire logic reset,
	// Select allowed
	output logic      sel_ok
);
	// Serial clock ceilings in MHz, kept by the host
	localparam int PLAIN_READ_CLOCK_LIMIT = 33;
	localparam int DUAL_READ_CLOCK_LIMIT  = 80;
	localparam int GENERAL_CLOCK_LIMIT    = 86;
	int cnt;

	// Shortened settle count; the real delay is far longer
	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt <= 0;
		end else if (cnt < POWERUP_SELECT_DELAY) begin
			cnt <= cnt + 1;
		end
	end
	assign sel_ok = (cnt == POWERUP_SELECT_DELAY);
endmodule

// >>> bench/flash_params_properties.sv
`timescale 1ns/1ps
module flash_params_properties #(
	parameter int PD = 3,
	parameter int WK = 4,
	parameter int WKI = 4
) (
	// Clock and reset
	input wire logic                  mclk,
	input wire logic                  reset,
	// Table port
	input wire logic [7:0]            table_addr,
	input wire logic [7:0]            table_data,
	// Requests
	input wire logic                  latch_set,
	input wire logic                  latch_clear,
	input wire logic                  op_start,
	input wire flash_params_pkg::op_t op_kind,
	input wire logic                  powerdown_req,
	input wire logic                  wake_req,
	input wire logic                  wake_with_id,
	// Status
	input wire logic                  busy,
	input wire logic                  write_latch_flag,
	input wire logic                  in_powerdown,
	input wire logic                  in_standby,
	input wire logic [7:0]            status_byte
);
	import flash_params_pkg::*;
	// Entry and wake are seen one edge after the last edge of their count; the bounds add no slack
	localparam int PDH = PD;
	localparam int WKH = (WK > WKI) ? WK : WKI;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	// Requests taken in their own state
	sequence s_pd_req;
		in_standby && powerdown_req && !op_start;
	endsequence
	sequence s_op_end;
		busy && !latch_set ##1 !busy;
	endsequence
	property p_busy_on;
		in_standby && op_start |=> busy;
	endproperty
	property p_busy_off;
		s_op_end |-> in_standby && !write_latch_flag;
	endproperty
	property p_stat;
		status_byte == {6'h00, write_latch_flag, busy};
	endproperty
	property p_excl;
		!(in_standby && in_powerdown);
	endproperty
	property p_set;
		latch_set && !busy |=> write_latch_flag;
	endproperty
	property p_blank;
		table_addr > 8'h6F || table_addr < 8'h60 |=> table_data == 8'hFF;
	endproperty
	property p_pd;
		s_pd_req |-> ##[1:PDH] in_powerdown;
	endproperty
	property p_wake;
		in_powerdown && wake_req |-> ##[1:WKH] in_standby;
	endproperty

	a_busy_on: assert property (p_busy_on)
		else $error("busy did not rise");
	a_busy_off: assert property (p_busy_off)
		else $error("op end left wrong state");
	a_stat: assert property (p_stat)
		else $error("status byte wrong");
	a_excl: assert property (p_excl)
		else $error("standby and power-down together");
	a_set: assert property (p_set)
		else $error("write latch not set");
	a_blank: assert property (p_blank)
		else $error("blank byte not FF");
	a_pd: assert property (p_pd)
		else $error("power-down late");
	a_wake: assert property (p_wake)
		else $error("wake late");
endmodule

bind flash_params_powerup flash_params_properties #(
	.PD(int'(PD_ENTRY_CYCLES)), .WK(int'(WAKE_CYCLES)),
	.WKI(int'(WAKE_ID_CYCLES))
) i_props (.mclk, .reset, .table_addr, .table_data, .latch_set,
	.latch_clear, .op_start, .op_kind, .powerdown_req, .wake_req,
	.wake_with_id, .busy, .write_latch_flag, .in_powerdown, .in_standby,
	.status_byte);

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import flash_params_pkg::*;
	logic       mclk = 0, reset = 1, latch_set = 0, latch_clear = 0;
	logic       op_start = 0, powerdown_req = 0, wake_req = 0;
	logic       wake_with_id = 0, busy, write_latch_flag;
	logic       in_powerdown, in_standby, sel_ok;
	logic [7:0] table_addr = 8'h00, table_data, status_byte;
	op_t        op_kind = OP_STATUS_WRITE;
	int         n_fail = 0, checked = 0, n;

	// Only the long counts are cut; entry, wake and byte keep theirs
	always #5 mclk = ~mclk;
	flash_params_powerup #(.SRW_CYCLES(32'h5), .PAGE_CYCLES(32'h7),
		.SECTOR_CYCLES(32'h8), .BLOCK_CYCLES(32'h9),
		.CHIP_CYCLES(32'hA)) i_flash_params_powerup (.mclk, .reset,
		.table_addr, .table_data, .latch_set, .latch_clear, .op_start,
		.op_kind, .powerdown_req, .wake_req, .wake_with_id, .busy,
		.write_latch_flag, .in_powerdown, .in_standby, .status_byte);
	host_model i_host_model (.mclk, .reset, .sel_ok);

	task automatic step;
		@(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Bounded wait so a stuck flag cannot hang the run
	task automatic wait_hi(ref logic s, input int lim);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			step;
			n++;
		end
	endtask
	// Latch is set first so its clearing at the op end shows
	task automatic run_op(input op_t k, input logic [31:0] len);
		latch_set = 1;
		step;
		latch_set = 0;
		op_start = 1;
		op_kind = k;
		step;
		op_start = 0;
		chk(status_byte, 8'h03);
		n = 0;
		while (busy === 1'b1 && n < int'(len) + 4) begin
			step;
			n++;
		end
		chk(n, len);
		chk(status_byte, 8'h00);
	endtask
	function automatic logic [7:0] tab(input logic [7:0] a);
		case (a)
			8'h61: return 8'h36;
			8'h63: return 8'h27;
			8'h64: return 8'hF6;
			8'h65: return 8'h4F;
			8'h68: return 8'hFE;
			8'h69: return 8'hCF;
			8'h60, 8'h62: return 8'h00;
			default: return 8'hFF;
		endcase
	endfunction

	// Main sequence
	initial begin
		repeat (8) @(posedge mclk);
		#1 reset = 0;
		wait_hi(sel_ok, 40);
		chk({in_standby, in_powerdown, write_latch_flag}, 3'b100);
		chk(status_byte, 8'h00);
		for (int a = 8'h5F; a <= 8'h70; a++) begin
			table_addr = 8'(a);
			step;
			chk(table_data, tab(8'(a)));
		end
		run_op(OP_STATUS_WRITE, 32'h5);
		run_op(OP_BYTE_PROGRAM, BYTE_CYC);
		run_op(OP_PAGE_PROGRAM, 32'h7);
		run_op(OP_SECTOR_CLEAR, 32'h8);
		run_op(OP_BLOCK_CLEAR, 32'h9);
		run_op(OP_CHIP_CLEAR, 32'hA);
		for (int i = 0; i < 2; i++) begin
			powerdown_req = 1;
			step;
			powerdown_req = 0;
			wait_hi(in_powerdown, int'(PD_ENTRY_CYC) + 4);
			chk(in_powerdown, 1'b1);
			chk(n, PD_ENTRY_CYC);
			op_start = 1;
			step;
			op_start = 0;
			step;
			chk(busy, 1'b0);
			wake_with_id = i[0];
			wake_req = 1;
			step;
			wake_req = 0;
			wait_hi(in_standby, int'(WAKE_ID_CYC) + int'(WAKE_CYC));
			chk(in_standby, 1'b1);
			chk(n, i[0] ? WAKE_ID_CYC : WAKE_CYC);
		end
		stop_test;
	end
	// Watchdog: the tests need about 340 us
	initial begin
		#500000;
		n_fail++;
		stop_test;
	end
endmodule
